// ==== core/fac_regs.vh ====
// Purpose: Constants for the field alarm comparator.
// Assumes: A 10 MHz system clock; field readings in signed micro-units.
// Notes:   Included by every design file of the block.
`ifndef FAC_REGS_VH
`define FAC_REGS_VH

// ==================================================================
// Timing
`define FAC_CLK_HZ        10000000
`define FAC_HOLD_MS       4000
`define FAC_HOLD_CYCLES   (`FAC_HOLD_MS * (`FAC_CLK_HZ / 1000))
`define FAC_BLINK_MS      250
`define FAC_BLINK_CYCLES  (`FAC_BLINK_MS * (`FAC_CLK_HZ / 1000))

// ==================================================================
// Setpoint limit: 350 k-units expressed in micro-units (3.5e11).
`define FAC_SP_LIMIT      40'h51_7DA0_2C00
`define FAC_MANT_MAX      20'h1869F

// ==================================================================
// Multiplier codes.
`define FAC_MULT_MICRO    3'h0
`define FAC_MULT_MILLI    3'h1
`define FAC_MULT_NONE     3'h2
`define FAC_MULT_KILO     3'h3
`define FAC_MULT_MEGA     3'h4

// ==================================================================
// Sort message codes.
`define FAC_SORT_BLANK    2'h0
`define FAC_SORT_LOW      2'h1
`define FAC_SORT_PASS     2'h2
`define FAC_SORT_HIGH     2'h3

// ==================================================================
// Reset values of the settings.
`define FAC_RST_ENABLE    1'b0
`define FAC_RST_MAG       1'b1
`define FAC_RST_INSIDE    1'b0
`define FAC_RST_AUDIBLE   1'b0
`define FAC_RST_SORT      1'b0
`define FAC_RST_LOW_SP    40'h00_1DCD_6500
`define FAC_RST_HIGH_SP   40'h00_D09D_C300

`endif

// ==== core/fac_key_hold.v ====
// Purpose: Classify the alarm key as a short press or a long hold.
// Assumes: Key level arrives from a pin, asynchronous to sys_clk_i.
// Notes:   Short press is reported on release; hold is reported once while held.
`include "fac_regs.vh"

module fac_key_hold #(
  parameter HOLD_CYCLES = `FAC_HOLD_CYCLES
) (
  // Clock and reset.
  input  wire sys_clk_i,
  input  wire reset_i,
  // Key pin.
  input  wire key_i,
  // Classified events.
  output reg  short_o,
  output reg  long_o
);

  // ==================================================================
  // Synchroniser and agreement filter.
  reg        s1_q;
  reg        s2_q;
  reg        s3_q;
  reg        key_q;
  reg        fired_q;
  reg [31:0] cnt_q;

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      key_q   <= 1'b0;
      fired_q <= 1'b0;
      cnt_q   <= 32'h0;
      short_o <= 1'b0;
      long_o  <= 1'b0;
    end else begin
      s1_q    <= key_i;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      short_o <= 1'b0;
      long_o  <= 1'b0;
      if (s2_q == s3_q) begin
        key_q <= s3_q;
      end
      if (key_q) begin
        if (!fired_q) begin
          if (cnt_q == HOLD_CYCLES - 1) begin
            long_o  <= 1'b1;
            fired_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
      end else begin
        // A release after a hold must not also start the short sequence.
        if (cnt_q != 32'h0 && !fired_q) begin
          short_o <= 1'b1;
        end
        cnt_q   <= 32'h0;
        fired_q <= 1'b0;
      end
    end
  end

endmodule

// ==== core/fac_blink.v ====
// Purpose: Square wave for the annunciator blink.
// Assumes: Single clock domain.
// Notes:   Phase restarts lit whenever the blink is not requested.
`include "fac_regs.vh"

module fac_blink #(
  parameter HALF_CYCLES = `FAC_BLINK_CYCLES
) (
  // Clock and reset.
  input  wire sys_clk_i,
  input  wire reset_i,
  // Control.
  input  wire run_i,
  // Phase out, high means lit.
  output reg  phase_o
);

  // ==================================================================
  // Half-period counter.
  reg [31:0] cnt_q;

  always @(posedge sys_clk_i) begin
    if (reset_i || !run_i) begin
      cnt_q   <= 32'h0;
      phase_o <= 1'b1;
    end else if (cnt_q == HALF_CYCLES - 1) begin
      cnt_q   <= 32'h0;
      phase_o <= ~phase_o;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

endmodule

// ==== core/fac_top.v ====
// Purpose: Alarm comparator and front-panel setup sequencer of a field meter.
// Assumes: Keypad strobes except the alarm key come from same-clock logic.
// Notes:   Setpoints and readings are signed integers in micro-units.
`include "fac_regs.vh"

module fac_top #(
  parameter HOLD_CYCLES  = `FAC_HOLD_CYCLES,
  parameter BLINK_CYCLES = `FAC_BLINK_CYCLES,
  parameter SP_LIMIT     = `FAC_SP_LIMIT
) (
  // Clock and reset.
  input  wire               sys_clk_i,
  input  wire               reset_i,
  // Alarm key pin, asynchronous level, high while pressed.
  input  wire               alarm_key_i,
  // Keypad strobes, one cycle each.
  input  wire               enter_i,
  input  wire               escape_i,
  input  wire               up_i,
  input  wire               down_i,
  input  wire               digit_i,
  input  wire [3:0]         digit_val_i,
  input  wire               minus_i,
  // Multipliers allowed by the field units.
  input  wire [2:0]         mult_min_i,
  input  wire [2:0]         mult_max_i,
  // Field reading.
  input  wire               reading_valid_i,
  input  wire signed [39:0] reading_i,
  // Indicators.
  output wire               led_o,
  output wire               beeper_o,
  output reg                alarm_active_o,
  output reg                alarm_low_o,
  output reg                alarm_high_o,
  output reg  [1:0]         sort_msg_o,
  // Settings and setup display.
  output reg                enable_o,
  output reg                magnitude_o,
  output reg                inside_o,
  output reg                audible_o,
  output reg                sort_o,
  output reg  signed [39:0] low_sp_o,
  output reg  signed [39:0] high_sp_o,
  output reg  [3:0]         screen_o,
  output reg                pending_o,
  output reg  [19:0]        entry_mant_o,
  output reg                entry_neg_o,
  output reg  [2:0]         entry_mult_o
);

  // ==================================================================
  // Screens of the setup sequence.
  localparam [3:0] SC_NORMAL  = 4'h0;
  localparam [3:0] SC_ENABLE  = 4'h1;
  localparam [3:0] SC_LO_NUM  = 4'h2;
  localparam [3:0] SC_LO_MULT = 4'h3;
  localparam [3:0] SC_HI_NUM  = 4'h4;
  localparam [3:0] SC_HI_MULT = 4'h5;
  localparam [3:0] SC_MAG     = 4'h6;
  localparam [3:0] SC_BAND    = 4'h7;
  localparam [3:0] SC_AUDIBLE = 4'h8;
  localparam [3:0] SC_SORT    = 4'h9;

  // ==================================================================
  // Helpers.
  function [39:0] mult_scale;
    input [2:0] m;
    begin
      case (m)
        `FAC_MULT_MICRO: mult_scale = 40'h00_0000_0001;
        `FAC_MULT_MILLI: mult_scale = 40'h00_0000_03E8;
        `FAC_MULT_NONE:  mult_scale = 40'h00_000F_4240;
        `FAC_MULT_KILO:  mult_scale = 40'h00_3B9A_CA00;
        `FAC_MULT_MEGA:  mult_scale = 40'hE8_D4A5_1000;
        default:         mult_scale = 40'h00_0000_0001;
      endcase
    end
  endfunction

  function is_select;
    input [3:0] s;
    begin
      is_select = (s == SC_ENABLE) || (s == SC_MAG) || (s == SC_BAND) ||
                  (s == SC_AUDIBLE) || (s == SC_SORT);
    end
  endfunction

  function is_value;
    input [3:0] s;
    begin
      is_value = (s == SC_LO_NUM) || (s == SC_LO_MULT) ||
                 (s == SC_HI_NUM) || (s == SC_HI_MULT);
    end
  endfunction

  // ==================================================================
  // Key classification and blink source.
  // The blink counter runs only while an alarm is active, so each onset starts lit.
  wire key_short;
  wire key_long;
  wire blink_phase;

  fac_key_hold #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_key (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .key_i     (alarm_key_i),
    .short_o   (key_short),
    .long_o    (key_long)
  );

  fac_blink #(
    .HALF_CYCLES (BLINK_CYCLES)
  ) u_blink (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .run_i     (alarm_active_o),
    .phase_o   (blink_phase)
  );

  // ==================================================================
  // Entered value, scaled and held within the legal span.
  // The product is kept at full width so that saturation sees true overflow.
  wire [59:0]        prod_w = entry_mant_o * mult_scale(entry_mult_o);
  wire               over_w = prod_w > {20'h0, SP_LIMIT[39:0]};
  wire [39:0]        mag_w  = over_w ? SP_LIMIT[39:0] : prod_w[39:0];
  wire signed [39:0] value_w = entry_neg_o ? -$signed(mag_w) : $signed(mag_w);

  // Clamp the multiplier into the range the field units allow.
  // The first multiplier offered is "none" unless the units forbid it.
  wire [2:0] mult_first = (`FAC_MULT_NONE < mult_min_i) ? mult_min_i :
                          (`FAC_MULT_NONE > mult_max_i) ? mult_max_i : `FAC_MULT_NONE;

  // ==================================================================
  // Setup sequencer.
  // The escape memory is cleared by any other key, so on value screens only two escapes
  // in a row abandon the sequence; a lone escape merely restarts the value.
  reg        esc_once_q;

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      screen_o     <= SC_NORMAL;
      pending_o    <= 1'b0;
      entry_mant_o <= 20'h0;
      entry_neg_o  <= 1'b0;
      entry_mult_o <= `FAC_MULT_NONE;
      esc_once_q   <= 1'b0;
      enable_o     <= `FAC_RST_ENABLE;
      magnitude_o  <= `FAC_RST_MAG;
      inside_o     <= `FAC_RST_INSIDE;
      audible_o    <= `FAC_RST_AUDIBLE;
      sort_o       <= `FAC_RST_SORT;
      low_sp_o     <= `FAC_RST_LOW_SP;
      high_sp_o    <= `FAC_RST_HIGH_SP;
    end else begin
      if (screen_o == SC_NORMAL) begin
        esc_once_q <= 1'b0;
        if (key_long) begin
          screen_o  <= SC_MAG;
          pending_o <= magnitude_o;
        end else if (key_short) begin
          screen_o  <= SC_ENABLE;
          pending_o <= enable_o;
        end
      end else if (is_select(screen_o)) begin
        if (escape_i) begin
          screen_o <= SC_NORMAL;
        end else if (up_i || down_i) begin
          pending_o <= ~pending_o;
        end else if (enter_i) begin
          case (screen_o)
            SC_ENABLE: begin
              enable_o     <= pending_o;
              screen_o     <= SC_LO_NUM;
              entry_mant_o <= 20'h0;
              entry_neg_o  <= 1'b0;
            end
            SC_MAG: begin
              magnitude_o <= pending_o;
              screen_o    <= SC_BAND;
              pending_o   <= inside_o;
            end
            SC_BAND: begin
              inside_o  <= pending_o;
              screen_o  <= SC_AUDIBLE;
              pending_o <= audible_o;
            end
            SC_AUDIBLE: begin
              audible_o <= pending_o;
              screen_o  <= SC_SORT;
              pending_o <= sort_o;
            end
            default: begin
              sort_o   <= pending_o;
              screen_o <= SC_NORMAL;
            end
          endcase
        end
      end else if (is_value(screen_o)) begin
        if (escape_i) begin
          if (esc_once_q) begin
            screen_o   <= SC_NORMAL;
            esc_once_q <= 1'b0;
          end else begin
            esc_once_q   <= 1'b1;
            entry_mant_o <= 20'h0;
            entry_neg_o  <= 1'b0;
            screen_o     <= (screen_o == SC_LO_NUM || screen_o == SC_LO_MULT) ? SC_LO_NUM : SC_HI_NUM;
          end
        end else if (screen_o == SC_LO_NUM || screen_o == SC_HI_NUM) begin
          if (digit_i) begin
            esc_once_q <= 1'b0;
            // Further digits are dropped once five are held, so the mantissa never overflows its limit.
            if (entry_mant_o <= (`FAC_MANT_MAX - 20'h9) / 20'hA && digit_val_i <= 4'h9) begin
              entry_mant_o <= entry_mant_o * 20'hA + {16'h0, digit_val_i};
            end
          end else if (minus_i) begin
            esc_once_q  <= 1'b0;
            entry_neg_o <= ~entry_neg_o;
          end else if (enter_i) begin
            esc_once_q   <= 1'b0;
            entry_mult_o <= mult_first;
            screen_o     <= (screen_o == SC_LO_NUM) ? SC_LO_MULT : SC_HI_MULT;
          end else if (up_i || down_i) begin
            esc_once_q <= 1'b0;
          end
        end else begin
          if (up_i) begin
            esc_once_q <= 1'b0;
            if (entry_mult_o < mult_max_i) begin
              entry_mult_o <= entry_mult_o + 3'h1;
            end
          end else if (down_i) begin
            esc_once_q <= 1'b0;
            if (entry_mult_o > mult_min_i) begin
              entry_mult_o <= entry_mult_o - 3'h1;
            end
          end else if (enter_i) begin
            esc_once_q <= 1'b0;
            if (screen_o == SC_LO_MULT) begin
              low_sp_o     <= value_w;
              screen_o     <= SC_HI_NUM;
              entry_mant_o <= 20'h0;
              entry_neg_o  <= 1'b0;
            end else begin
              high_sp_o <= value_w;
              screen_o  <= SC_NORMAL;
            end
          end else if (digit_i || minus_i) begin
            esc_once_q <= 1'b0;
          end
        end
      end else begin
        screen_o <= SC_NORMAL;
      end
    end
  end

  // ==================================================================
  // Comparison against the setpoints.
  // Readings are compared every cycle but only registered on a valid strobe,
  // so a setting takes effect from the next reading on, but clearing enable or sort blanks its outputs at once.
  // The most negative reading has no positive twin; in magnitude mode it
  // folds onto itself and compares as a large negative value.
  wire signed [39:0] cmp_w   = (magnitude_o && reading_i < 0) ? -reading_i : reading_i;
  wire               below_w = cmp_w < low_sp_o;
  wire               above_w = cmp_w > high_sp_o;
  wire               hit_w   = inside_o ? (!below_w && !above_w)
                                        : (below_w || above_w);

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      alarm_active_o <= 1'b0;
      alarm_low_o    <= 1'b0;
      alarm_high_o   <= 1'b0;
      sort_msg_o     <= `FAC_SORT_BLANK;
    end else begin
      if (!enable_o) begin
        alarm_active_o <= 1'b0;
        alarm_low_o    <= 1'b0;
        alarm_high_o   <= 1'b0;
      end else if (reading_valid_i) begin
        alarm_active_o <= hit_w;
        alarm_low_o    <= !inside_o && below_w;
        alarm_high_o   <= !inside_o && above_w;
      end
      // The sort message is a pure display path; it feeds nothing above.
      if (!sort_o) begin
        sort_msg_o <= `FAC_SORT_BLANK;
      end else if (reading_valid_i) begin
        sort_msg_o <= below_w ? `FAC_SORT_LOW : above_w ? `FAC_SORT_HIGH : `FAC_SORT_PASS;
      end
    end
  end

  // ==================================================================
  // Indicators.
  // Both indicators are combinational from registers, so they follow the
  // alarm state without another cycle of delay.
  assign led_o    = enable_o && (!alarm_active_o || blink_phase);
  assign beeper_o = alarm_active_o && audible_o;

endmodule

// ==== test/fac_top_assertions.sv ====
// Purpose: Concurrent checks on the ports of the field alarm comparator.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   The blink bound of 20 cycles suits a bench half period of 8.
module fac_chk (
  // Clock and reset.
  input logic               sys_clk_i,
  input logic               reset_i,
  // Keypad and reading.
  input logic               escape_i,
  input logic               up_i,
  input logic               down_i,
  input logic               digit_i,
  input logic               minus_i,
  input logic               reading_valid_i,
  input logic signed [39:0] reading_i,
  // Indicators and settings.
  input logic               led_o,
  input logic               beeper_o,
  input logic               alarm_active_o,
  input logic               alarm_low_o,
  input logic               alarm_high_o,
  input logic [1:0]         sort_msg_o,
  input logic               enable_o,
  input logic               magnitude_o,
  input logic               inside_o,
  input logic               audible_o,
  input logic               sort_o,
  input logic signed [39:0] low_sp_o,
  input logic signed [39:0] high_sp_o,
  input logic [3:0]         screen_o,
  input logic [19:0]        entry_mant_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  // ==========
  // Indicators.
  beep_gate_a: assert property (beeper_o == (alarm_active_o && audible_o))
    else $error("beeper does not follow alarm and audible");
  led_lit_a: assert property (enable_o && !alarm_active_o |-> led_o)
    else $error("led dark while enabled and quiet");
  quiet_off_a: assert property (!enable_o [*2] |-> !led_o && !alarm_active_o && !beeper_o)
    else $error("alarm outputs live while disabled");
  blink_run_a: assert property ($rose(alarm_active_o) && enable_o |-> ##[1:20] (!led_o || !alarm_active_o || !enable_o))
    else $error("led does not blink during alarm");

  // ==========
  // Comparison. Settings only change in setup screens, hence the screen guard.
  low_out_a: assert property (reading_valid_i && enable_o && !inside_o && screen_o == 4'h0 && !reading_i[39]
    && reading_i < low_sp_o |=> alarm_active_o && alarm_low_o) else $error("low alarm missed");
  mag_high_a: assert property (reading_valid_i && enable_o && magnitude_o && !inside_o && screen_o == 4'h0
    && reading_i[39] && -reading_i > high_sp_o |=> alarm_active_o && alarm_high_o) else $error("magnitude missed");
  in_band_a: assert property (reading_valid_i && enable_o && inside_o && screen_o == 4'h0 && !reading_i[39]
    && reading_i >= low_sp_o && reading_i <= high_sp_o |=> alarm_active_o) else $error("inside alarm missed");
  sort_pass_a: assert property (reading_valid_i && sort_o && screen_o == 4'h0 && !reading_i[39]
    && reading_i >= low_sp_o && reading_i <= high_sp_o |=> sort_msg_o == 2'h2) else $error("pass message missed");

  // ==========
  // Setup sequence.
  entry_path_a: assert property ($past(screen_o) == 4'h0 && screen_o != 4'h0 |-> screen_o == 4'h1 || screen_o == 4'h6)
    else $error("setup opened on a wrong screen");
  esc_select_a: assert property (escape_i && (screen_o == 4'h1 || screen_o > 4'h5)
    |=> screen_o == 4'h0 && $stable(enable_o) && $stable(inside_o)) else $error("escape did not discard");
  esc_restart_a: assert property (escape_i && screen_o == 4'h2 && entry_mant_o != 20'h0
    |=> screen_o == 4'h2 && entry_mant_o == 20'h0) else $error("escape did not restart entry");
  esc_abandon_a: assert property (escape_i && screen_o == 4'h2 ##1 !(digit_i || up_i || down_i || minus_i)
    ##1 escape_i && screen_o == 4'h2 |=> screen_o == 4'h0) else $error("second escape did not abandon");
endmodule

// ==== test/fac_panel.sv ====
// Purpose: Front-panel keypad and field reading source for the comparator.
// Assumes: Strobes rise 1 ns after a rising edge and stand one cycle.
// Notes:   Released data lines show the inverse of their last value.
module fac_panel (
  // Clock.
  input  logic               sys_clk_i,
  // Keys.
  output logic               alarm_key_o,
  output logic               enter_o,
  output logic               escape_o,
  output logic               up_o,
  output logic               down_o,
  output logic               digit_o,
  output logic [3:0]         digit_val_o,
  output logic               minus_o,
  // Field reading.
  output logic               reading_valid_o,
  output logic signed [39:0] reading_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {alarm_key_o, enter_o, escape_o, up_o, down_o, digit_o, minus_o, reading_valid_o} = 8'h0;
    digit_val_o = 4'h0;
    reading_o = 40'h0;
  end

  // ==========
  // Alarm key held for n cycles, then time for the design to settle.
  task automatic press(input int n);
    @(posedge sys_clk_i);
    #1;
    alarm_key_o = 1'b1;
    repeat (n) @(posedge sys_clk_i);
    #1;
    alarm_key_o = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    #1;
  endtask

  // Codes 0 to 9 are digits; 10 enter, 11 escape, 12 up, 13 down, 14 minus.
  task automatic keys(input int ks[]);
    foreach (ks[i]) begin
      @(posedge sys_clk_i);
      #1;
      case (ks[i])
        10: enter_o = 1'b1;
        11: escape_o = 1'b1;
        12: up_o = 1'b1;
        13: down_o = 1'b1;
        14: minus_o = 1'b1;
        default: digit_o = 1'b1;
      endcase
      digit_val_o = ks[i][3:0];
      @(posedge sys_clk_i);
      #1;
      {enter_o, escape_o, up_o, down_o, digit_o, minus_o} = 6'h0;
      digit_val_o = ~digit_val_o;
    end
  endtask

  task automatic send(input logic signed [39:0] v);
    @(posedge sys_clk_i);
    #1;
    reading_valid_o = 1'b1;
    reading_o = v;
    @(posedge sys_clk_i);
    #1;
    reading_valid_o = 1'b0;
    reading_o = ~v;
  endtask
endmodule

// ==== test/fac_tb.sv ====
// Purpose: Self-checking bench for the field alarm comparator.
// Assumes: Shortened hold and blink counts keep the run brief.
// Notes:   Alarm results are queued by the driver and matched by a monitor.
`include "fac_regs.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic               sys_clk_i, reset_i, alarm_key_i, enter_i, escape_i, up_i, down_i, digit_i, minus_i;
  logic               reading_valid_i, led_o, beeper_o, alarm_active_o, alarm_low_o, alarm_high_o;
  logic               enable_o, magnitude_o, inside_o, audible_o, sort_o, pending_o, entry_neg_o;
  logic [3:0]         digit_val_i, screen_o;
  logic [2:0]         mult_min_i, mult_max_i, entry_mult_o;
  logic [1:0]         sort_msg_o;
  logic [19:0]        entry_mant_o;
  logic signed [39:0] reading_i, low_sp_o, high_sp_o, r;
  logic               en = `FAC_RST_ENABLE, mag = `FAC_RST_MAG, ins = `FAC_RST_INSIDE;
  logic               aud = `FAC_RST_AUDIBLE, srt = `FAC_RST_SORT;
  logic signed [39:0] lo = `FAC_RST_LOW_SP, hi = `FAC_RST_HIGH_SP;
  logic [5:0]         exp_q[$];
  int                 miscompares = 0, samples_checked = 0;

  fac_top #(.HOLD_CYCLES(20), .BLINK_CYCLES(8)) dut (
    .sys_clk_i, .reset_i, .alarm_key_i, .enter_i, .escape_i, .up_i, .down_i, .digit_i, .digit_val_i,
    .minus_i, .mult_min_i, .mult_max_i, .reading_valid_i, .reading_i, .led_o, .beeper_o, .alarm_active_o,
    .alarm_low_o, .alarm_high_o, .sort_msg_o, .enable_o, .magnitude_o, .inside_o, .audible_o, .sort_o,
    .low_sp_o, .high_sp_o, .screen_o, .pending_o, .entry_mant_o, .entry_neg_o, .entry_mult_o
  );
  fac_panel panel (
    .sys_clk_i, .alarm_key_o(alarm_key_i), .enter_o(enter_i), .escape_o(escape_i), .up_o(up_i),
    .down_o(down_i), .digit_o(digit_i), .digit_val_o(digit_val_i), .minus_o(minus_i),
    .reading_valid_o(reading_valid_i), .reading_o(reading_i)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // ==========
  // Expected alarm, low, high, beeper and sort message for one reading.
  function automatic logic [5:0] expect_f(input logic signed [39:0] v);
    logic signed [39:0] m;
    logic               below, above, act;
    m = (mag && v < 0) ? -v : v;
    below = m < lo;
    above = m > hi;
    act = en && (ins ? !(below || above) : (below || above));
    return {act, en && !ins && below, en && !ins && above, act && aud,
            srt ? (below ? 2'h1 : (above ? 2'h3 : 2'h2)) : 2'h0};
  endfunction

  task automatic check(input string what, input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic verify();
    check("settings", {35'h0, enable_o, magnitude_o, inside_o, audible_o, sort_o}, {35'h0, en, mag, ins, aud, srt});
    check("low_sp", low_sp_o, lo);
    check("high_sp", high_sp_o, hi);
    check("screen", {36'h0, screen_o}, 40'h0);
  endtask

  task automatic rd(input logic signed [39:0] v);
    exp_q.push_back(expect_f(v));
    panel.send(v);
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    if (reading_valid_i === 1'b1) begin
      @(negedge sys_clk_i);
      check("alarm", {34'h0, alarm_active_o, alarm_low_o, alarm_high_o, beeper_o, sort_msg_o}, {34'h0, exp_q.pop_front()});
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    reset_i = 1'b1;
    mult_min_i = `FAC_MULT_MICRO;
    mult_max_i = `FAC_MULT_MEGA;
    void'($urandom(32'h61AB6AD4));
    repeat (16) @(posedge sys_clk_i);
    #1;
    reset_i = 1'b0;
    verify();
    rd(-(`FAC_SP_LIMIT + 40'h1));
    $display("test reset_values done");
    // ==========
    // Short press: enable, low 2 kilo, high 400 kilo which must saturate.
    panel.press(5);
    check("pend_scr", {35'h0, pending_o, screen_o}, 40'h1);
    panel.keys('{12, 10});
    en = 1'b1;
    check("screen", {36'h0, screen_o}, 40'h2);
    // Units that allow only kilo: the first multiplier and both keys are clamped.
    mult_min_i = `FAC_MULT_KILO;
    mult_max_i = `FAC_MULT_KILO;
    panel.keys('{2, 10, 12, 10});
    lo = 40'h00_7735_9400;
    check("screen", {36'h0, screen_o}, 40'h4);
    panel.keys('{4, 0, 0, 10, 13, 12});
    check("mult", {37'h0, entry_mult_o}, {37'h0, `FAC_MULT_KILO});
    panel.keys('{10});
    hi = `FAC_SP_LIMIT;
    verify();
    check("led", {39'h0, led_o}, 40'h1);
    $display("test short_setup done");
    // Magnitude and outside, with the equal-setpoint and random in-band cases.
    rd(-(`FAC_SP_LIMIT + 40'h1));
    repeat (20) @(posedge sys_clk_i);
    rd(lo);
    rd(40'h1);
    repeat (6) begin
      r = lo + {8'h0, $urandom};
      if ($urandom_range(1) != 0) begin
        r = -r;
      end
      rd(r);
    end
    $display("test magnitude_outside done");
    // ==========
    // Long hold: algebraic, inside, audible on, sort on.
    panel.press(30);
    check("pend_scr", {35'h0, pending_o, screen_o}, 40'h16);
    panel.keys('{12, 10, 12, 10, 12, 10, 12, 10});
    mag = 1'b0;
    ins = 1'b1;
    aud = 1'b1;
    srt = 1'b1;
    verify();
    rd(-(`FAC_SP_LIMIT + 40'h1));
    rd(40'h00_D09D_C300);
    rd(`FAC_SP_LIMIT + 40'h1);
    $display("test long_setup done");
    // Escape on a selection screen, then restart and abandon of a number.
    panel.press(5);
    panel.keys('{12, 11});
    verify();
    panel.press(5);
    panel.keys('{10, 7, 14, 11});
    check("entry", {15'h0, entry_neg_o, entry_mant_o, screen_o}, 40'h2);
    panel.keys('{11});
    verify();
    $display("test escapes done");
    // Disable the alarm; a band reading must stay silent.
    panel.press(5);
    panel.keys('{12, 10, 11, 11});
    en = 1'b0;
    verify();
    rd(40'h00_D09D_C300);
    check("led", {39'h0, led_o}, 40'h0);
    $display("test disable done");
    tally_and_finish();
  end
endmodule

bind fac_top fac_chk u_chk (
  .sys_clk_i, .reset_i, .escape_i, .up_i, .down_i, .digit_i, .minus_i, .reading_valid_i, .reading_i, .led_o,
  .beeper_o, .alarm_active_o, .alarm_low_o, .alarm_high_o, .sort_msg_o, .enable_o, .magnitude_o,
  .inside_o, .audible_o, .sort_o, .low_sp_o, .high_sp_o, .screen_o, .entry_mant_o
);
